// *** baro_pkg.sv ***
// Purpose: shared constants for the sensor command link
// Assumes: 100 MHz system clock, 7-bit bus address
// Notes:   conversion figures are plain defaults
package baro_pkg;
  localparam int          CLK_NS     = 10;
  localparam logic [6:0]  DEV_ADDR   = 7'h76;
  localparam logic [7:0]  CMD_ADC    = 8'h00;
  localparam logic [3:0]  CMD_PRESS  = 4'h4;
  localparam logic [3:0]  CMD_TEMP   = 4'h5;
  localparam logic [3:0]  CMD_PROM   = 4'hA;
  localparam logic [2:0]  RATIO_TOP  = 3'h4;
  localparam int          PROM_WORDS = 7;
  localparam int          CRC_LSB    = 12;
  localparam logic [15:0] CRC_POLY   = 16'h3000;
  localparam logic [15:0] CRC_KEEP   = 16'h0FFF;
  // conversion time at the lowest ratio, doubled per ratio step
  localparam int          CONV_TYP_NS = 500000;
  localparam int          CONV_MAX_NS = 600000;
  localparam int          CONV_TYP_CYCLES = CONV_TYP_NS / CLK_NS;
  localparam int          CONV_MAX_CYCLES = (CONV_MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SCL_QUARTER = 4;
  // controller register map
  localparam logic [3:0]  REG_CMD    = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_RDATA  = 4'h8;
  localparam int          OP_LSB     = 8;
  localparam logic [1:0]  OP_WRITE   = 2'h1;
  localparam logic [1:0]  OP_READ2   = 2'h2;
  localparam int          ST_BUSY    = 0;
  localparam int          ST_NACK    = 1;
  localparam int          ST_REFUSED = 2;
  localparam int          ST_WAIT    = 3;
  localparam int          ST_LOADED  = 4;
  localparam int          ST_CRC_OK  = 5;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef logic [7:0][15:0] prom_t;

  function automatic logic [3:0] crc4(input prom_t w);
    prom_t       m;
    logic [15:0] rem;
    logic [7:0]  b;
    m = w;
    m[0] = m[0] & CRC_KEEP;
    m[7] = 16'h0000;
    rem = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      b = i[0] ? m[i / 2][7:0] : m[i / 2][15:8];
      rem = rem ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
        rem = rem[15] ? ({rem[14:0], 1'b0} ^ CRC_POLY) : {rem[14:0], 1'b0};
      end
    end
    return rem[15:12];
  endfunction
endpackage

// *** baro_if.sv ***
// Purpose: two-wire link between controller and sensor
// Assumes: open-drain data line with pull-up
// Notes:   clock line is driven by the controller only
`timescale 1ns/100ps
interface baro_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda_i;

  // wired-and with pull-up
  assign sda_i = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda_i);
  modport device (input scl, output dev_sda_o, output dev_sda_oe, input sda_i);
endinterface

// *** sensor_end.sv ***
// Purpose: sensor end: command decode, PROM and conversion timer
// Assumes: link logic runs on the bus clock, aclk is the oscillator
// Notes:   link flops clear asynchronously since the bus clock idles
`timescale 1ns/100ps
module sensor_end #(
  parameter logic [6:0]       VERSION_FIELD = 7'h15, // arbitrary value
  parameter logic [4:0]       FACTORY_BITS  = 5'h00,
  parameter logic [5:0][15:0] COEFS         = {16'h6000, 16'h5000, 16'h4000,
                                               16'h3000, 16'h2000, 16'h1000},
  parameter int               CONV_CYCLES   = baro_pkg::CONV_TYP_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  baro_if.device           link,
  input  wire logic [23:0] pressure_in,
  input  wire logic [23:0] temperature_in,
  output logic             conv_busy
);
  typedef enum {M_NONE, M_PROM, M_ADC} mode_t;

  // ************
  // PROM image
  // ************
  baro_pkg::prom_t raw_w;
  baro_pkg::prom_t prom_w;
  always_comb begin
    raw_w = '0;
    for (int i = 1; i < baro_pkg::PROM_WORDS; i++) begin
      raw_w[i] = COEFS[i - 1];
    end
    raw_w[0] = {4'h0, VERSION_FIELD, FACTORY_BITS};
    prom_w = raw_w;
    prom_w[0][15:baro_pkg::CRC_LSB] = baro_pkg::crc4(raw_w);
  end

  // ************
  // link side
  // ************
  logic        start_tg_q;
  logic        seen_q;
  logic [3:0]  cnt_q;
  logic [2:0]  byte_q;
  logic [6:0]  sr_q;
  logic        sel_q;
  logic        rd_q;
  mode_t       mode_q;
  logic [2:0]  addr_q;
  logic [2:0]  ratio_q;
  logic        temp_q;
  logic        conv_tg_q;
  logic        done_s1_q;
  logic        done_s2_q;
  logic        done_seen_q;
  logic        valid_q;
  logic [23:0] adc_word_q;
  logic        oe_q;
  logic        done_tg_q;
  logic [23:0] result_q;

  // start: data falls while clock high
  always_ff @(negedge link.sda_i or negedge aresetn) begin
    if (!aresetn) start_tg_q <= 1'b0;
    else if (link.scl) start_tg_q <= ~start_tg_q;
  end

  wire        fresh    = start_tg_q != seen_q;
  wire [3:0]  idx      = fresh ? 4'h0 : cnt_q;
  wire [2:0]  bidx     = fresh ? 3'h0 : byte_q;
  wire [7:0]  rx_byte  = {sr_q, link.sda_i};
  wire        byte_end = idx == 4'h7;
  wire        ack_slot = idx == 4'h8;
  wire        cmd_take = byte_end && bidx != 3'h0 && sel_q && !rd_q;
  wire        is_prom  = rx_byte[7:4] == baro_pkg::CMD_PROM && !rx_byte[0];
  wire        is_conv  = (rx_byte[7:4] == baro_pkg::CMD_PRESS || rx_byte[7:4] == baro_pkg::CMD_TEMP)
                         && !rx_byte[0] && rx_byte[3:1] <= baro_pkg::RATIO_TOP;
  wire        is_adc   = rx_byte == baro_pkg::CMD_ADC;
  wire        done_new = done_s2_q != done_seen_q;

  always_ff @(posedge link.scl or negedge aresetn) begin
    if (!aresetn) begin
      seen_q <= 1'b0;
      cnt_q  <= 4'h0;
      byte_q <= 3'h0;
      sr_q   <= 7'h00;
      sel_q  <= 1'b0;
      rd_q   <= 1'b0;
    end else begin
      seen_q <= start_tg_q;
      cnt_q  <= ack_slot ? 4'h0 : idx + 4'h1;
      byte_q <= bidx;
      sr_q   <= rx_byte[6:0];
      if (ack_slot && bidx != 3'h7) byte_q <= bidx + 3'h1;
      if (byte_end && bidx == 3'h0) begin
        sel_q <= rx_byte[7:1] == baro_pkg::DEV_ADDR;
        rd_q  <= rx_byte[0];
      end
      if (ack_slot && rd_q && bidx != 3'h0 && link.sda_i) sel_q <= 1'b0;
    end
  end

  // command decode and result hand-off
  always_ff @(posedge link.scl or negedge aresetn) begin
    if (!aresetn) begin
      mode_q      <= M_NONE;
      addr_q      <= 3'h0;
      ratio_q     <= 3'h0;
      temp_q      <= 1'b0;
      conv_tg_q   <= 1'b0;
      done_s1_q   <= 1'b0;
      done_s2_q   <= 1'b0;
      done_seen_q <= 1'b0;
      valid_q     <= 1'b0;
      adc_word_q  <= 24'h000000;
    end else begin
      done_s1_q   <= done_tg_q;
      done_s2_q   <= done_s1_q;
      done_seen_q <= done_s2_q;
      if (cmd_take && is_prom) begin
        mode_q <= M_PROM;
        addr_q <= rx_byte[3:1];
      end
      if (cmd_take && is_conv) begin
        conv_tg_q <= ~conv_tg_q;
        temp_q    <= rx_byte[4];
        ratio_q   <= rx_byte[3:1];
      end
      if (cmd_take && is_adc) begin
        mode_q     <= M_ADC;
        adc_word_q <= valid_q ? result_q : 24'h000000;
      end
      // a finish seen in the same edge still counts
      if (done_new) valid_q <= 1'b1;
      else if (cmd_take && (is_adc || is_conv)) valid_q <= 1'b0;
    end
  end

  wire [23:0] out_w   = mode_q == M_PROM ? {prom_w[addr_q], 8'h00} :
                        mode_q == M_ADC ? adc_word_q : 24'h000000;
  wire [5:0]  bit_pos = {byte_q - 3'h1, cnt_q[2:0]};
  wire        tx_bit  = bit_pos < 6'h18 ? out_w[5'(6'h17 - bit_pos)] : 1'b1;
  wire        ack_drv = cnt_q == 4'h8 && sel_q && (byte_q == 3'h0 || !rd_q);
  wire        dat_drv = cnt_q < 4'h8 && sel_q && rd_q && byte_q != 3'h0 && !tx_bit;

  always_ff @(negedge link.scl or negedge aresetn) begin
    if (!aresetn) oe_q <= 1'b0;
    else oe_q <= !fresh && (ack_drv || dat_drv);
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = oe_q;

  // ************
  // converter
  // ************
  logic        conv_s1_q;
  logic        conv_s2_q;
  logic        conv_seen_q;
  logic        busy_q;
  logic        tsel_q;
  logic [23:0] tmr_q;
  wire         conv_new = conv_s2_q != conv_seen_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_s1_q   <= 1'b0;
      conv_s2_q   <= 1'b0;
      conv_seen_q <= 1'b0;
      busy_q      <= 1'b0;
      tsel_q      <= 1'b0;
      tmr_q       <= 24'h000000;
      result_q    <= 24'h000000;
      done_tg_q   <= 1'b0;
    end else begin
      conv_s1_q   <= conv_tg_q;
      conv_s2_q   <= conv_s1_q;
      conv_seen_q <= conv_s2_q;
      if (conv_new) begin
        busy_q <= 1'b1;
        tsel_q <= temp_q;
        tmr_q  <= 24'(CONV_CYCLES) << ratio_q;
      end else if (busy_q) begin
        tmr_q <= tmr_q - 24'h000001;
        if (tmr_q == 24'h000001) begin
          busy_q    <= 1'b0;
          result_q  <= tsel_q ? temperature_in : pressure_in;
          done_tg_q <= ~done_tg_q;
        end
      end
    end
  end

  assign conv_busy = busy_q;
endmodule

// *** bus_host.sv ***
// Purpose: bus controller that drives the sensor over the two-wire link
// Assumes: AXI4-Lite command port, one transfer per command
// Notes:   link clock is aclk divided by four quarters
`timescale 1ns/100ps
module bus_host #(
  parameter int AW        = 4,
  parameter int QUARTER   = baro_pkg::SCL_QUARTER,
  parameter int CONV_WAIT = baro_pkg::CONV_MAX_CYCLES
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  baro_if.host               link
);
  typedef enum {H_IDLE, H_START, H_BITS, H_STOP} hstate_t;

  // ************
  // register port
  // ************
  logic        wr_rdy_q;
  logic        rd_rdy_q;
  logic        bvalid_q;
  logic        rvalid_q;
  logic [1:0]  bresp_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] status_w;

  wire        wr_go   = awvalid && wvalid && !wr_rdy_q && !bvalid_q;
  wire        rd_go   = arvalid && !rd_rdy_q && !rvalid_q;
  wire        cmd_hit = wr_rdy_q && awaddr[3:0] == baro_pkg::REG_CMD && wstrb[1:0] == 2'h3;
  wire        st_hit  = araddr[3:0] == baro_pkg::REG_STATUS;
  wire        rd_hit  = araddr[3:0] == baro_pkg::REG_RDATA;
  wire        map_ok  = st_hit || rd_hit || araddr[3:0] == baro_pkg::REG_CMD;
  logic [23:0] rx_q;
  wire [31:0] rd_mux  = st_hit ? status_w : rd_hit ? {8'h00, rx_q} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_rdy_q <= 1'b0;
      rd_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q  <= 2'h0;
      rresp_q  <= 2'h0;
      rdata_q  <= 32'h00000000;
    end else begin
      wr_rdy_q <= wr_go;
      rd_rdy_q <= rd_go;
      if (wr_rdy_q) begin
        bvalid_q <= 1'b1;
        bresp_q  <= awaddr[3:0] == baro_pkg::REG_CMD ? baro_pkg::RESP_OKAY : baro_pkg::RESP_SLVERR;
      end else if (bready) bvalid_q <= 1'b0;
      if (rd_rdy_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= map_ok ? baro_pkg::RESP_OKAY : baro_pkg::RESP_SLVERR;
      end else if (rready) rvalid_q <= 1'b0;
    end
  end

  assign awready = wr_rdy_q;
  assign wready  = wr_rdy_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = rd_rdy_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // ************
  // command check
  // ************
  hstate_t     st_q;
  logic [23:0] wait_q;
  logic [6:0]  loaded_q;
  logic        refused_q;
  logic        nack_q;
  baro_pkg::prom_t prom_q;

  wire [1:0] op       = wdata[baro_pkg::OP_LSB +: 2];
  wire [7:0] c        = wdata[7:0];
  wire       c_conv   = (c[7:4] == baro_pkg::CMD_PRESS || c[7:4] == baro_pkg::CMD_TEMP)
                        && !c[0] && c[3:1] <= baro_pkg::RATIO_TOP;
  wire       c_adc    = c == baro_pkg::CMD_ADC;
  wire       all_load = &loaded_q;
  wire       refuse   = st_q != H_IDLE || op == 2'h0
                        || (op == baro_pkg::OP_WRITE && c_conv && wait_q != 24'h000000)
                        || (op == baro_pkg::OP_WRITE && c_adc && wait_q != 24'h000000)
                        || (op == baro_pkg::OP_WRITE && c_adc && !all_load);
  wire       accept   = cmd_hit && !refuse;
  wire       crc_ok   = baro_pkg::crc4(prom_q) == prom_q[0][15:baro_pkg::CRC_LSB];

  always_comb begin
    status_w = 32'h00000000;
    status_w[baro_pkg::ST_BUSY]    = st_q != H_IDLE;
    status_w[baro_pkg::ST_NACK]    = nack_q;
    status_w[baro_pkg::ST_REFUSED] = refused_q;
    status_w[baro_pkg::ST_WAIT]    = wait_q != 24'h000000;
    status_w[baro_pkg::ST_LOADED]  = all_load;
    status_w[baro_pkg::ST_CRC_OK]  = all_load && crc_ok;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) wait_q <= 24'h000000;
    else if (accept && op == baro_pkg::OP_WRITE && c_conv) wait_q <= 24'(CONV_WAIT) << c[3:1];
    else if (wait_q != 24'h000000) wait_q <= wait_q - 24'h000001;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) refused_q <= 1'b0;
    else if (cmd_hit) refused_q <= refuse;
  end

  // ************
  // link engine
  // ************
  logic       sda_s1_q;
  logic       sda_s2_q;
  logic [7:0] qc_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [1:0] lastb_q;
  logic       rdop_q;
  logic       abort_q;
  logic       scl_q;
  logic       oe_q;
  logic [7:0] cmd_q;

  wire       qtick    = qc_q == 8'h00;
  wire [3:0] nxt_bit  = bit_q == 4'h8 ? 4'h0 : bit_q + 4'h1;
  wire [1:0] nxt_byte = bit_q == 4'h8 ? byte_q + 2'h1 : byte_q;
  wire       nxt_wdir = nxt_byte == 2'h0 || !rdop_q;
  wire [7:0] txb      = nxt_byte == 2'h0 ? {baro_pkg::DEV_ADDR, rdop_q} : cmd_q;
  wire       drv      = nxt_wdir ? (nxt_bit < 4'h8 && !txb[3'(4'h7 - nxt_bit)])
                                 : (nxt_bit == 4'h8 && nxt_byte != lastb_q);
  wire       cur_wdir = byte_q == 2'h0 || !rdop_q;
  wire       sample   = st_q == H_BITS && qtick && ph_q == 2'h2;
  wire       ack_miss = sample && bit_q == 4'h8 && cur_wdir && sda_s2_q;
  wire       fin      = st_q == H_STOP && qtick && ph_q == 2'h2;
  wire       prom_cmd = cmd_q[7:4] == baro_pkg::CMD_PROM && !cmd_q[0];
  wire       prom_fin = fin && rdop_q && lastb_q == baro_pkg::OP_READ2 && !abort_q
                        && prom_cmd && cmd_q[3:1] != 3'h7;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      qc_q     <= 8'h00;
    end else begin
      sda_s1_q <= link.sda_i;
      sda_s2_q <= sda_s1_q;
      qc_q     <= qtick ? 8'(QUARTER - 1) : qc_q - 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= H_IDLE;
      ph_q    <= 2'h0;
      bit_q   <= 4'h0;
      byte_q  <= 2'h0;
      lastb_q <= 2'h0;
      rdop_q  <= 1'b0;
      abort_q <= 1'b0;
      scl_q   <= 1'b1;
      oe_q    <= 1'b0;
      cmd_q   <= 8'h00;
      rx_q    <= 24'h000000;
    end else if (st_q == H_IDLE) begin
      if (accept) begin
        st_q    <= H_START;
        ph_q    <= 2'h0;
        bit_q   <= 4'h8;
        byte_q  <= 2'h3;
        abort_q <= 1'b0;
        rx_q    <= 24'h000000;
        rdop_q  <= op != baro_pkg::OP_WRITE;
        lastb_q <= op;
        if (op == baro_pkg::OP_WRITE) cmd_q <= c;
      end
    end else if (qtick) begin
      ph_q <= ph_q + 2'h1;
      case (st_q)
        H_START: begin
          // first data bit moves a quarter after the clock falls, never with it
          if (ph_q == 2'h0) oe_q <= 1'b1;
          if (ph_q == 2'h1) scl_q <= 1'b0;
          if (ph_q == 2'h2) begin
            oe_q   <= drv;
            bit_q  <= nxt_bit;
            byte_q <= nxt_byte;
            ph_q   <= 2'h0;
            st_q   <= H_BITS;
          end
        end
        H_BITS: begin
          if (ph_q == 2'h0) scl_q <= 1'b1;
          if (ph_q == 2'h2) begin
            scl_q <= 1'b0;
            if (ack_miss) abort_q <= 1'b1;
            if (!cur_wdir && bit_q < 4'h8) rx_q <= {rx_q[22:0], sda_s2_q};
          end
          if (ph_q == 2'h3) begin
            if (bit_q == 4'h8 && (abort_q || byte_q == lastb_q)) begin
              st_q <= H_STOP;
              oe_q <= 1'b1;
              ph_q <= 2'h0;
            end else begin
              oe_q   <= drv;
              bit_q  <= nxt_bit;
              byte_q <= nxt_byte;
            end
          end
        end
        H_STOP: begin
          if (ph_q == 2'h0) scl_q <= 1'b1;
          if (ph_q == 2'h1) oe_q <= 1'b0;
          if (ph_q == 2'h2) st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) nack_q <= 1'b0;
    else if (ack_miss) nack_q <= 1'b1;
    else if (accept) nack_q <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prom_q   <= '0;
      loaded_q <= 7'h00;
    end else if (prom_fin) begin
      prom_q[cmd_q[3:1]]   <= rx_q[15:0];
      loaded_q[cmd_q[3:1]] <= 1'b1;
    end
  end

  assign link.scl         = scl_q;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = oe_q;
endmodule

// *** link_monitor.sv ***
// Purpose: protocol checks on the two-wire sensor link
// Assumes: link clock is a divided aclk, so aclk samples it cleanly
// Notes:   frame position is rebuilt from the wire levels alone
`timescale 1ns/100ps
module link_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda_i
);
  // ********
  // frame tracking
  // ********
  logic       scl_q;
  logic       sda_q;
  logic       in_frame_q;
  logic       rw_q;
  logic       ack_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  wire        start_w = scl && scl_q && sda_q && !sda_i;
  wire        stop_w  = scl && scl_q && !sda_q && sda_i;
  wire        rise_w  = scl && !scl_q;

  // the rise just before a stop counts as bit 0 of a byte never sent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_q, sda_q, in_frame_q, rw_q, ack_q, bit_q, byte_q} <= {2'b11, 3'b000, 4'h0, 3'h0};
    end else begin
      scl_q <= scl;
      sda_q <= sda_i;
      if (start_w) begin
        {in_frame_q, bit_q, byte_q} <= {1'b1, 4'h0, 3'h0};
      end else if (stop_w) begin
        in_frame_q <= 1'b0;
      end else if (rise_w) begin
        bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        if (bit_q == 4'h8) byte_q <= byte_q + 3'h1;
        if (bit_q == 4'h8) ack_q <= sda_i;
        if (bit_q == 4'h7 && byte_q == 3'h0) rw_q <= sda_i;
      end
    end
  end

  // ********
  // assertions
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_dev_edge_timing: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data moved while link clock high");
  a_reset_link_idle: assert property ($rose(aresetn) |-> scl && !host_sda_oe && !dev_sda_oe)
    else $error("link not idle after reset");
  a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
    else $error("link clock high phase too short");
  a_addr_byte_ack: assert property (rise_w && byte_q == 3'h0 && bit_q == 4'h8 |-> !sda_i)
    else $error("address byte not acknowledged");
  a_stop_whole_bytes: assert property (stop_w |-> bit_q == 4'h1 && byte_q >= 3'h2)
    else $error("stop inside a byte or frame too short");
  a_last_ack_kind: assert property (stop_w |-> ack_q == rw_q)
    else $error("wrong acknowledge before stop");
  a_host_sda_framing: assert property ($changed(host_sda_oe) && scl && $past(scl) |-> host_sda_oe != in_frame_q)
    else $error("host data moved with clock high outside start or stop");
  a_dev_quiet_idle: assert property (!in_frame_q |-> !dev_sda_oe)
    else $error("device drives data outside a frame");
  a_open_drain_low: assert property (!host_sda_o && !dev_sda_o)
    else $error("data line driven high instead of released");

  c_write_frame: cover property (stop_w && !rw_q);
  c_word_read: cover property (stop_w && rw_q && byte_q == 3'h3);
  c_result_read: cover property (stop_w && rw_q && byte_q == 3'h4);
endmodule

// *** sensor_prom_and_adc_readout_tb.sv ***
// Purpose: bench for the controller and sensor joined over the link
// Assumes: short conversion counts, link clock divided from aclk
// Notes:   expected PROM words are built here from the sensor parameters
`timescale 1ns/100ps
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module sensor_prom_and_adc_readout_tb;
  // ********
  // design and clock
  // ********
  localparam logic [6:0]       VERS = 7'h2A; // arbitrary value
  localparam logic [4:0]       FACT = 5'h13;
  localparam logic [5:0][15:0] COEF = {16'h6A5F, 16'h5B4E, 16'h4C3D, 16'h3D2C, 16'h2E1B, 16'h1F0A};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, conv_busy;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [23:0] pressure_in, temperature_in;
  logic [15:0] prom [8];
  int          n_fail, num_checks;

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  baro_if baro_if_i ();
  // host wait runs from acceptance, so it must cover the command frame plus the conversion
  bus_host #(.CONV_WAIT(600)) bus_host_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(baro_if_i.host));
  sensor_end #(.VERSION_FIELD(VERS), .FACTORY_BITS(FACT), .COEFS(COEF), .CONV_CYCLES(150)) sensor_end_i (
    .aclk(aclk), .aresetn(aresetn), .link(baro_if_i.device), .pressure_in(pressure_in),
    .temperature_in(temperature_in), .conv_busy(conv_busy));
  link_monitor link_monitor_i (.aclk(aclk), .aresetn(aresetn), .scl(baro_if_i.scl),
    .host_sda_o(baro_if_i.host_sda_o), .host_sda_oe(baro_if_i.host_sda_oe), .dev_sda_o(baro_if_i.dev_sda_o),
    .dev_sda_oe(baro_if_i.dev_sda_oe), .sda_i(baro_if_i.sda_i));

  // ********
  // helpers
  // ********
  task automatic tally_and_finish(input logic hung);
    if (hung) n_fail++;
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // crc nibble of word 0 and the spare word must be zero when called
  function automatic logic [3:0] crc_ref();
    logic [15:0] r;
    logic [7:0]  b;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      b = i[0] ? prom[i / 2][7:0] : prom[i / 2][15:8];
      r = r ^ {8'h00, b};
      for (int k = 0; k < 8; k++) r = r[15] ? ({r[14:0], 1'b0} ^ 16'h3000) : {r[14:0], 1'b0};
    end
    return r[15:12];
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, v, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
    if (n >= 100) tally_and_finish(1'b1);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rr);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    {v, rr} = {rdata, rresp};
    if (n >= 100) tally_and_finish(1'b1);
  endtask

  task automatic wait_bit(input int b, input logic v);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      rd(baro_pkg::REG_STATUS, d, r);
      n++;
    end while (d[b] !== v && n < 5000);
    if (n >= 5000) tally_and_finish(1'b1);
  endtask

  task automatic expect_bit(input int b, input logic e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(baro_pkg::REG_STATUS, d, r);
    `CHK("status bit", e, d[b])
  endtask

  task automatic cmd(input logic [1:0] op, input logic [7:0] c);
    wr(baro_pkg::REG_CMD, {22'h000000, op, c}, baro_pkg::RESP_OKAY);
    wait_bit(baro_pkg::ST_BUSY, 1'b0);
  endtask

  // ********
  // sequence
  // ********
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  c;
    logic [23:0] e;
    // nba so the asynchronously cleared link flops see a falling edge
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb, wdata, pressure_in, temperature_in} = '0;
    {n_fail, num_checks} = {32'sd0, 32'sd0};
    prom[0] = {4'h0, VERS, FACT};
    for (int k = 1; k < 7; k++) prom[k] = COEF[k - 1];
    prom[7] = 16'h0000;
    prom[0][15:12] = crc_ref();
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cmd(baro_pkg::OP_WRITE, baro_pkg::CMD_ADC);
    expect_bit(baro_pkg::ST_REFUSED, 1'b1);
    expect_bit(baro_pkg::ST_LOADED, 1'b0);
    wr(4'hC, 32'h00000000, baro_pkg::RESP_SLVERR);
    wr(baro_pkg::REG_STATUS, 32'h00000000, baro_pkg::RESP_SLVERR);
    rd(4'hC, d, r);
    `CHK("unmapped read", {baro_pkg::RESP_SLVERR, 32'h00000000}, {r, d})
    cmd(2'h0, 8'hA0);
    expect_bit(baro_pkg::ST_REFUSED, 1'b1);
    for (int k = 0; k < 7; k++) begin
      cmd(baro_pkg::OP_WRITE, {baro_pkg::CMD_PROM, 3'(k), 1'b0});
      cmd(baro_pkg::OP_READ2, 8'h00);
      rd(baro_pkg::REG_RDATA, d, r);
      `CHK("prom word", {baro_pkg::RESP_OKAY, prom[k]}, {r, d[15:0]})
    end
    expect_bit(baro_pkg::ST_NACK, 1'b0);
    expect_bit(baro_pkg::ST_LOADED, 1'b1);
    expect_bit(baro_pkg::ST_CRC_OK, 1'b1);
    // every ratio of both kinds, with early reads and reissue refused
    for (int i = 0; i < 10; i++) begin
      c = {(i < 5) ? baro_pkg::CMD_PRESS : baro_pkg::CMD_TEMP, 4'(2 * (i % 5))};
      pressure_in <= 24'hA5C300 + 24'(i);
      temperature_in <= 24'h3C5A00 + 24'(i);
      e = (i < 5) ? 24'hA5C300 + 24'(i) : 24'h3C5A00 + 24'(i);
      cmd(baro_pkg::OP_WRITE, c);
      `CHK("conversion running", 1'b1, conv_busy)
      expect_bit(baro_pkg::ST_WAIT, 1'b1);
      cmd(baro_pkg::OP_WRITE, baro_pkg::CMD_ADC);
      expect_bit(baro_pkg::ST_REFUSED, 1'b1);
      cmd(baro_pkg::OP_WRITE, c);
      expect_bit(baro_pkg::ST_REFUSED, 1'b1);
      wait_bit(baro_pkg::ST_WAIT, 1'b0);
      cmd(baro_pkg::OP_WRITE, baro_pkg::CMD_ADC);
      expect_bit(baro_pkg::ST_REFUSED, 1'b0);
      cmd(2'h3, 8'h00);
      rd(baro_pkg::REG_RDATA, d, r);
      `CHK("adc result", e, d[23:0])
    end
    cmd(baro_pkg::OP_WRITE, baro_pkg::CMD_ADC);
    cmd(2'h3, 8'h00);
    rd(baro_pkg::REG_RDATA, d, r);
    `CHK("repeated adc read", 24'h000000, d[23:0])
    tally_and_finish(1'b0);
  end
endmodule
